// ===== hdl/adcis_pkg.sv
package adcis_pkg;
  // ****************************************************************
  // Register fields
  // ****************************************************************
  typedef struct packed {
    logic regBit;
    logic referenceChoiceHi;
    logic referenceChoiceMid;
    logic referenceChoiceLo;
    logic clockSource;
    logic polarityChoice;
    logic keepConfigN;
    logic dontCare;
  } adcis_setup_t;

  typedef struct packed {
    logic regBit;
    logic scanPatternHi;
    logic scanPatternLo;
    logic [3:0] channelSelect;
    logic inputModeBit;
  } adcis_config_t;

  typedef struct packed {
    logic [11:0] plusCode;
    logic [11:0] minusCode;
  } adcis_sample_t;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [7:0] SETUP_RESET = 8'h82;
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  // Arbitrary bus address, set by the integrator
  localparam logic [6:0] SLAVE_ADDR = 7'h35;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic DIR_READ = 1'h1;
  localparam logic SEL_SETUP = 1'h1;
  localparam logic CLK_EXTERNAL = 1'h1;
  localparam logic MODE_SINGLE = 1'h1;
  localparam logic POL_BIPOLAR = 1'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 10000000;
  localparam int FS_RATE_SPS = 22200;
  localparam int HS_RATE_SPS = 94400;
  localparam logic [9:0] FS_CONV_CYC = 10'(CLK_HZ / FS_RATE_SPS);
  localparam logic [9:0] HS_CONV_CYC = 10'(CLK_HZ / HS_RATE_SPS);

  localparam logic signed [12:0] CODE_MAX = 13'sh07ff;
  localparam logic signed [12:0] CODE_MIN = -13'sh0800;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_DATA = 3'h2,
    ST_CONV = 3'h7,
    ST_SKIP = 3'h5
  } adcis_state_t;
endpackage : adcis_pkg

// ===== hdl/adcis_slave.sv
`timescale 1ns/1ps
// Overview of operation
// - Single-ended: channel measured against ground
// - Differential: plus minus minus of pair
// - Differential unipolar negative input gives zero
// - Straight binary unipolar, two's complement bipolar
// - Single-ended always unipolar, polarity ignored
// - One bit per clock, nine-clock byte transfer
// - SDA change with SCL high is control
// - Detect START and STOP conditions
// - Repeated START keeps speed mode
// - Ack low through ninth clock high
// - Idle watches START then own address
// - Address LSB gives direction, 1 reads
// - Acknowledge own address for one clock
// - Power up in fast/standard speed mode
// - Master code: not-acknowledge then high-speed
// - STOP in high-speed reverts to fast/standard
// - Top bit routes byte setup or config
// - One or more bytes, each acknowledged
// - Polarity bit 2, reference bits 6:4
// - Setup bit 1 low resets configuration
// - Configuration byte layout, input mode 1
// - Internal timing: stretch SCL during conversion
module adcis_slave
  import adcis_pkg::*;
(
  input wire logic refClk,
  input wire logic srst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic sclOut,
  output logic sclOe,
  input wire adcis_sample_t sample,
  output adcis_setup_t setupQ,
  output adcis_config_t configQ,
  output logic hsModeQ,
  output logic convBusyQ,
  output logic resultValidQ,
  output logic [11:0] resultCodeQ
);
  // ****************************************************************
  // Bus edge and condition detection
  // ****************************************************************
  logic sclPrev_q;
  logic sdaPrev_q;
  wire sclRise = sclIn & ~sclPrev_q;
  wire sclFall = ~sclIn & sclPrev_q;
  // Only SDA moving while SCL stays high is a condition
  wire sclHeld = sclIn & sclPrev_q;
  wire startSeen = sclHeld & sdaPrev_q & ~sdaIn;
  wire stopSeen = sclHeld & ~sdaPrev_q & sdaIn;

  always_ff @(posedge refClk) begin
    if (srst) begin
      sclPrev_q <= 1'h1;
      sdaPrev_q <= 1'h1;
    end else begin
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
    end
  end

  // ****************************************************************
  // Protocol state
  // ****************************************************************
  adcis_state_t state_q;
  adcis_state_t state_d;
  logic [3:0] bitCnt_q;
  logic [3:0] bitCnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic readDir_q;
  logic readDir_d;
  logic isAddrAck_q;
  logic isAddrAck_d;
  logic hsPending_q;
  logic hsPending_d;
  logic hsMode_d;
  logic sdaOe_d;
  logic sclOe_d;
  logic [9:0] convCnt_q;
  logic [9:0] convCnt_d;
  adcis_setup_t setup_d;
  adcis_config_t config_d;

  wire [7:0] inByte = {shift_q[6:0], sdaIn};
  wire byteDone = sclFall & (bitCnt_q == BYTE_BITS);
  wire addrMatch = shift_q[7:1] == SLAVE_ADDR;
  wire masterCode = shift_q[7:3] == HS_CODE_TOP;
  wire setupSel = shift_q[7] == SEL_SETUP;
  wire internalClk = setupQ.clockSource != CLK_EXTERNAL;
  wire [9:0] convLen = hsModeQ ? HS_CONV_CYC : FS_CONV_CYC;
  wire convDone = convCnt_q == convLen;

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    readDir_d = readDir_q;
    isAddrAck_d = isAddrAck_q;
    hsPending_d = hsPending_q;
    hsMode_d = hsModeQ;
    sdaOe_d = sdaOe;
    sclOe_d = sclOe;
    convCnt_d = convCnt_q;
    setup_d = setupQ;
    config_d = configQ;
    if (sclRise && bitCnt_q < BYTE_BITS) begin
      // One data bit per SCL period
      shift_d = inByte;
      bitCnt_d = bitCnt_q + 4'h1;
    end
    if (stopSeen) begin
      state_d = ST_IDLE;
      hsMode_d = 1'h0;
      hsPending_d = 1'h0;
      sdaOe_d = 1'h0;
      sclOe_d = 1'h0;
    end else if (startSeen) begin
      // Repeated START leaves the speed mode alone
      state_d = ST_ADDR;
      bitCnt_d = 4'h0;
      sdaOe_d = 1'h0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (byteDone) begin
            bitCnt_d = 4'h0;
            isAddrAck_d = 1'h1;
            readDir_d = shift_q[0] == DIR_READ;
            if (masterCode) begin
              // Leave SDA released over the ninth clock
              hsPending_d = 1'h1;
              state_d = ST_ACK;
            end else if (addrMatch) begin
              sdaOe_d = 1'h1;
              state_d = ST_ACK;
            end else begin
              state_d = ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          // Release only after the ninth clock falls
          if (sclFall) begin
            sdaOe_d = 1'h0;
            bitCnt_d = 4'h0;
            if (hsPending_q) begin
              hsMode_d = 1'h1;
              hsPending_d = 1'h0;
              state_d = ST_SKIP;
            end else if (!readDir_q || !isAddrAck_q) begin
              state_d = ST_DATA;
            end else if (internalClk) begin
              // Hold SCL low until the result is ready
              sclOe_d = 1'h1;
              convCnt_d = 10'h0;
              state_d = ST_CONV;
            end else begin
              // External timing read-out lies outside this block
              state_d = ST_SKIP;
            end
          end
        end
        ST_DATA: begin
          if (byteDone) begin
            bitCnt_d = 4'h0;
            isAddrAck_d = 1'h0;
            sdaOe_d = 1'h1;
            state_d = ST_ACK;
            if (setupSel) begin
              setup_d = adcis_setup_t'(shift_q);
              if (!shift_q[1]) begin
                config_d = adcis_config_t'(CONFIG_RESET);
              end
            end else begin
              config_d = adcis_config_t'(shift_q);
            end
          end
        end
        ST_CONV: begin
          convCnt_d = convCnt_q + 10'h1;
          if (convDone) begin
            sclOe_d = 1'h0;
            state_d = ST_SKIP;
          end
        end
        default: begin
          // Idle and skip wait for the next START
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Short groups, each loaded from the next-state logic above
  always_ff @(posedge refClk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
    end
  end

  always_ff @(posedge refClk) begin
    if (srst) begin
      shift_q <= 8'h00;
      readDir_q <= 1'h0;
    end else begin
      shift_q <= shift_d;
      readDir_q <= readDir_d;
    end
  end

  always_ff @(posedge refClk) begin
    if (srst) begin
      isAddrAck_q <= 1'h0;
      hsPending_q <= 1'h0;
    end else begin
      isAddrAck_q <= isAddrAck_d;
      hsPending_q <= hsPending_d;
    end
  end

  always_ff @(posedge refClk) begin
    if (srst) begin
      hsModeQ <= 1'h0;
      convCnt_q <= 10'h0;
    end else begin
      hsModeQ <= hsMode_d;
      convCnt_q <= convCnt_d;
    end
  end

  // Both pins let go on reset so a stale ack or stretch cannot hang
  always_ff @(posedge refClk) begin
    if (srst) begin
      sdaOe <= 1'h0;
      sclOe <= 1'h0;
    end else begin
      sdaOe <= sdaOe_d;
      sclOe <= sclOe_d;
    end
  end

  always_ff @(posedge refClk) begin
    if (srst) begin
      setupQ <= adcis_setup_t'(SETUP_RESET);
      configQ <= adcis_config_t'(CONFIG_RESET);
    end else begin
      setupQ <= setup_d;
      configQ <= config_d;
    end
  end

  // ****************************************************************
  // Result coding
  // ****************************************************************
  // Single-ended ignores the minus sample: ground is the reference
  wire singleEnded = configQ.inputModeBit == MODE_SINGLE;
  wire [11:0] minusUsed = singleEnded ? 12'h000 : sample.minusCode;
  wire signed [12:0] diff = $signed({1'b0, sample.plusCode}) -
    $signed({1'b0, minusUsed});
  // Single-ended forces unipolar whatever the polarity bit
  wire bipolar = !singleEnded && setupQ.polarityChoice == POL_BIPOLAR;
  wire [11:0] uniCode = diff[12] ? 12'h000 : diff[11:0];
  // Half the reference each way keeps the unipolar step size, so the
  // code is the plain difference, clipped at the two's complement ends
  wire bipHigh = diff > CODE_MAX;
  wire bipLow = diff < CODE_MIN;
  wire [11:0] bipCode = bipHigh ? CODE_MAX[11:0] :
    bipLow ? CODE_MIN[11:0] : diff[11:0];
  wire [11:0] codeNow = bipolar ? bipCode : uniCode;
  wire convEnd = state_q == ST_CONV && convDone;

  always_ff @(posedge refClk) begin
    if (srst) begin
      resultCodeQ <= 12'h000;
      resultValidQ <= 1'h0;
      convBusyQ <= 1'h0;
      sdaOut <= 1'h0;
      sclOut <= 1'h0;
    end else begin
      convBusyQ <= state_d == ST_CONV;
      resultValidQ <= convEnd;
      if (convEnd) begin
        resultCodeQ <= codeNow;
      end
      // Open-drain: only ever pulls low
      sdaOut <= 1'h0;
      sclOut <= 1'h0;
    end
  end
endmodule : adcis_slave

// ===== sim/adcis_bus_master.sv
`timescale 1ns/1ps
// ************
// Bus master model
// ************
module adcis_bus_master (
  input wire logic refClk,
  input wire logic sdaOe,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sclOut,
  output wire logic sclLine,
  output wire logic sdaLine
);
  logic sclDrv = 1'b1;
  logic sdaDrv = 1'b1;
  // Pull-ups: a released line reads high unless a party pulls it low
  assign sclLine = sclDrv && (!sclOe || sclOut);
  assign sdaLine = sdaDrv && (!sdaOe || sdaOut);
  task automatic step(input logic c, input logic d);
    sclDrv <= c;
    sdaDrv <= d;
    repeat (4) @(posedge refClk);
  endtask : step
  // Also a repeated START when entered with SCL low
  task automatic start();
    step(sclDrv, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  task automatic pulse(input logic b, output logic seen);
    step(1'b0, b);
    step(1'b1, b);
    seen = sdaLine;
    step(1'b0, b);
  endtask : pulse
  task automatic xfer(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, s);
    ack = !s;
  endtask : xfer
endmodule : adcis_bus_master

// ===== sim/adcis_slave_asserts.sv
`timescale 1ns/1ps
// ************
// Bus checks
// ************
module adcis_slave_asserts
  import adcis_pkg::*;
(
  input wire logic refClk,
  input wire logic srst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire adcis_setup_t setupQ,
  input wire logic hsModeQ,
  input wire logic convBusyQ,
  input wire logic resultValidQ
);
  logic sclPrev;
  logic [1:0] riseCnt;
  logic [9:0] convCnt;
  wire logic sclRise = sclIn && !sclPrev;
  wire logic [9:0] convLen = (hsModeQ ? HS_CONV_CYC : FS_CONV_CYC) + 10'h001;
  // Counters, as the stretch is far too long for a repetition
  always_ff @(posedge refClk) begin
    sclPrev <= sclIn;
    riseCnt <= (srst || !sdaOe) ? 2'h0 : riseCnt + {1'b0, sclRise};
    convCnt <= (srst || !sclOe) ? 10'h000 : convCnt + 10'h001;
  end
  default clocking cb @(posedge refClk); endclocking
  default disable iff (srst);
  a_pins_low: assert property (
    (sdaOe |-> !sdaOut) and (sclOe |-> !sclOut)) else $error("pin high");
  a_sda_lowphase: assert property (
    $changed(sdaOe) |-> !sclIn && !$past(sclIn)) else $error("sda moved");
  a_ack_one_clock: assert property (
    $fell(sdaOe) |-> riseCnt == 2'h1) else $error("ack length");
  a_hs_nack: assert property (
    $rose(hsModeQ) |-> !sclIn && !sdaOe && !$past(sdaOe, 4))
    else $error("hs entry");
  a_stop_exits: assert property (
    sclIn && $past(sclIn) && $rose(sdaIn) |-> ##[1:2] !hsModeQ)
    else $error("stop");
  a_restart_keeps: assert property (
    sclIn && $past(sclIn) && $fell(sdaIn) && hsModeQ |=> hsModeQ [*4])
    else $error("restart");
  a_conv_len: assert property (
    $fell(sclOe) |-> convCnt == convLen) else $error("stretch length");
  a_valid_pulse: assert property (
    $fell(convBusyQ) |-> ##[0:2] resultValidQ ##1 !resultValidQ)
    else $error("valid");
  a_busy_stretch: assert property (
    convBusyQ == sclOe) else $error("busy");
  a_int_clock: assert property (
    $rose(sclOe) |-> setupQ.clockSource != CLK_EXTERNAL) else $error("clk");
  c_hs_entry: cover property ($rose(hsModeQ));
  c_conv_done: cover property ($fell(sclOe));
  c_ack: cover property ($fell(sdaOe));
endmodule : adcis_slave_asserts

bind adcis_slave adcis_slave_asserts u_chk (
  .refClk(refClk), .srst(srst), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe),
  .setupQ(setupQ), .hsModeQ(hsModeQ), .convBusyQ(convBusyQ),
  .resultValidQ(resultValidQ));

// ===== sim/tb.sv
`timescale 1ns/1ps
// ************
// Converter slave bench
// ************
module tb
  import adcis_pkg::*;
;
  logic refClk;
  logic srst;
  adcis_sample_t sample;
  wire logic sclLine;
  wire logic sdaLine;
  logic sdaOut;
  logic sdaOe;
  logic sclOut;
  logic sclOe;
  adcis_setup_t setupQ;
  adcis_config_t configQ;
  logic hsModeQ;
  logic convBusyQ;
  logic resultValidQ;
  logic [11:0] resultCodeQ;
  int numErrors = 0;
  int testsRun = 0;
  localparam logic [7:0] WR = {SLAVE_ADDR, 1'b0};
  adcis_slave dut (.refClk(refClk), .srst(srst), .sclIn(sclLine),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut),
    .sclOe(sclOe), .sample(sample), .setupQ(setupQ), .configQ(configQ),
    .hsModeQ(hsModeQ), .convBusyQ(convBusyQ),
    .resultValidQ(resultValidQ), .resultCodeQ(resultCodeQ));
  adcis_bus_master bm (.refClk(refClk), .sdaOe(sdaOe), .sclOe(sclOe),
    .sdaOut(sdaOut), .sclOut(sclOut), .sclLine(sclLine),
    .sdaLine(sdaLine));
  initial begin
    refClk = 1'b0;
    forever #50 refClk = ~refClk;
  end
  task automatic chk(input string what, input logic [11:0] exp, got);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : giveVerdict
  task automatic send(input logic [7:0] b, input logic expAck);
    logic ack;
    bm.xfer(b, ack);
    chk("ack", 12'(expAck), 12'(ack));
  endtask : send
  // Opens with a repeated START, then waits out the clock stretch
  task automatic rd(input logic [11:0] exp);
    int n;
    bm.start();
    send({SLAVE_ADDR, 1'b1}, 1'b1);
    chk("busy", 12'h001, 12'(convBusyQ));
    n = 0;
    while (resultValidQ !== 1'b1 && n < 1000) begin
      @(posedge refClk);
      n++;
    end
    if (resultValidQ !== 1'b1) begin
      chk("valid", 12'h001, 12'(resultValidQ));
      giveVerdict();
    end else begin
      chk("result", exp, resultCodeQ);
    end
  endtask : rd
  task automatic do_reset();
    srst <= 1'b1;
    repeat (20) @(posedge refClk);
    srst <= 1'b0;
    @(posedge refClk);
  endtask : do_reset
  task automatic t_defaults();
    chk("setup", 12'h082, 12'(setupQ));
    chk("config", 12'h001, 12'(configQ));
    chk("hs", 12'h000, 12'(hsModeQ));
    $display("defaults test done");
  endtask : t_defaults
  task automatic t_write();
    bm.start();
    send(WR, 1'b1);
    send(8'hf6, 1'b1);
    send(8'h3a, 1'b1);
    bm.stop();
    chk("setup", 12'h0f6, 12'(setupQ));
    chk("config", 12'h03a, 12'(configQ));
    bm.start();
    send(WR, 1'b1);
    send(8'h84, 1'b1);
    bm.stop();
    chk("setup", 12'h084, 12'(setupQ));
    chk("config", 12'h001, 12'(configQ));
    $display("write test done");
  endtask : t_write
  task automatic t_foreign();
    bm.start();
    send({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    bm.stop();
    chk("config", 12'h001, 12'(configQ));
    $display("foreign test done");
  endtask : t_foreign
  // Bipolar stays set from the write test; a single-ended read must ignore the 7ff minus sample
  task automatic t_hs();
    sample <= {12'h0a5, 12'h7ff};
    bm.start();
    send(8'h0d, 1'b0);
    chk("hs", 12'h001, 12'(hsModeQ));
    bm.start();
    send(WR, 1'b1);
    send(8'h01, 1'b1);
    rd(12'h0a5);
    chk("hs", 12'h001, 12'(hsModeQ));
    bm.stop();
    chk("hs", 12'h000, 12'(hsModeQ));
    $display("speed mode test done");
  endtask : t_hs
  // External timing: the read is acked but SCL is never stretched
  task automatic t_ext();
    bm.start();
    send(WR, 1'b1);
    send(8'h8a, 1'b1);
    bm.start();
    send({SLAVE_ADDR, 1'b1}, 1'b1);
    repeat (8) @(posedge refClk);
    chk("busy", 12'h000, 12'(convBusyQ));
    bm.stop();
    chk("setup", 12'h08a, 12'(setupQ));
    $display("external clock test done");
  endtask : t_ext
  task automatic t_conv();
    logic [51:0] tc [5];
    tc = '{{8'h86, 8'h0b, 12'h123, 12'h456, 12'h123},
           {8'h82, 8'h00, 12'h100, 12'h300, 12'h000},
           {8'h82, 8'h00, 12'h300, 12'h100, 12'h200},
           {8'h86, 8'h00, 12'h100, 12'h300, 12'he00},
           {8'h86, 8'h00, 12'hfff, 12'h000, 12'h7ff}};
    foreach (tc[i]) begin
      bm.start();
      send(WR, 1'b1);
      send(tc[i][43:36], 1'b1);
      send(tc[i][51:44], 1'b1);
      sample <= {tc[i][35:24], tc[i][23:12]};
      rd(tc[i][11:0]);
      bm.stop();
    end
    $display("conversion test done");
  endtask : t_conv
  initial begin
    srst = 1'b1;
    sample = '0;
    do_reset();
    t_defaults();
    t_write();
    t_foreign();
    t_hs();
    t_ext();
    t_conv();
    do_reset();
    t_defaults();
    giveVerdict();
  end
endmodule : tb
